// file: design/hupl_pkg.sv
// Constants, types and register map of the UTMI+ style link-side logic.
// Function
// RULE1: Mode code picks normal, non-driving or raw.
// RULE2: Output reference clock; link signals follow it.
// RULE3: Line bit 0 is D+, bit 1 D-.
// RULE4: Suspended or resuming: line passes straight through.
// RULE5: Line codes: SE0 0, J 1, K 2, SE1 3.
// RULE6: Host mode raises detach flag on disconnect.
// RULE7: Entering low power clears the detach flag.
// RULE8: Eight bit data bus, bit 7 most significant.
// RULE9: Receive valid while holding register has a byte.
// RULE10: Link samples data on clock rise when valid.
// RULE11: Pull-down select connects the D- pull-down.
// RULE12: Receive fault timed exactly like receive data; here fault moves on every reference rise, data only without transmit valid.
// RULE13: Receive fault may rise anytime; one means error.
// RULE14: Accept pulses after each transmit byte taken.
// RULE15: Valid rise starts SYNC, fall starts EOP.
// RULE16: Link waits five clock rises after reset.
// RULE17: Low power request stops clocks, minimal power.
// RULE18: Only one side drives the data bus.
package hupl_pkg;
	// ****************************************************************
	// Link side constants
	// ****************************************************************
	localparam int         DATA_W       = 8;
	localparam int         REF_CLK_MHZ  = 60;
	localparam logic [1:0] OPM_NORMAL   = 2'h0;
	localparam logic [1:0] OPM_NONDRV   = 2'h1;
	localparam logic [1:0] OPM_RAW      = 2'h2;
	localparam logic [1:0] OPM_RSVD     = 2'h3;
	localparam logic [1:0] LC_SE0       = 2'h0;
	localparam logic [1:0] LC_J         = 2'h1;
	localparam logic [1:0] LC_K         = 2'h2;
	localparam logic [1:0] LC_SE1       = 2'h3;
	localparam int         RESUME_W     = 5;
	localparam logic [4:0] RESUME_LAST  = 5'h0F;
	localparam logic [4:0] RESUME_STEP  = 5'h01;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int         ADDR_W       = 8;
	localparam int         REG_W        = 32;
	localparam int         STAT_W       = 6;
	localparam logic [7:0] REG_STATUS   = 8'h00;
	localparam logic [7:0] REG_MASK     = 8'h04;
	localparam logic [7:0] REG_CTRL     = 8'h08;
	localparam logic [7:0] REG_STATE    = 8'h0C;
	localparam int         CTRL_HOST    = 0;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {PW_RUN, PW_SUSP, PW_RESUME} hupl_pwr_t;
	typedef struct packed {
		logic              dp;
		logic              dm;
		logic              detach_detect;
		logic              rx_stb;
		logic              rx_err_stb;
		logic [DATA_W-1:0] rx_byte;
	} hupl_ana_in_t;
	typedef struct packed {
		logic              pulldown_en;
		logic              term_off;
		logic              stuff_bypass;
		logic              clocks_stopped;
		logic              sync_start;
		logic              eop_start;
		logic              tx_stb;
		logic [DATA_W-1:0] tx_byte;
	} hupl_ana_out_t;
endpackage

// file: design/hupl_top.sv
// Link-side logic of the transceiver with its AXI4-Lite register slave.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module hupl_top (
	// Clock, reset and freeze.
	input  logic                               aclk,
	input  logic                               aresetn,
	input  logic                               ce,
	// AXI4-Lite slave.
	input  logic [hupl_pkg::ADDR_W-1:0]        awaddr,
	input  logic [2:0]                         awprot,
	input  logic                               awvalid,
	output logic                               awready,
	input  logic [hupl_pkg::REG_W-1:0]         wdata,
	input  logic [3:0]                         wstrb,
	input  logic                               wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  logic                               bready,
	input  logic [hupl_pkg::ADDR_W-1:0]        araddr,
	input  logic [2:0]                         arprot,
	input  logic                               arvalid,
	output logic                               arready,
	output logic [hupl_pkg::REG_W-1:0]         rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  logic                               rready,
	output logic                               irq,
	// Link interface.
	input  logic [1:0]                         operating_mode_select,
	input  logic                               host_pulldown_select,
	input  logic                               low_power_request_n,
	input  logic                               transmit_word_valid,
	input  logic [hupl_pkg::DATA_W-1:0]        data_in,
	output logic [hupl_pkg::DATA_W-1:0]        data_out,
	output logic                               data_oe,
	output logic                               phy_reference_clock_out,
	output logic [1:0]                         line_condition,
	output logic                               downstream_detach_flag,
	output logic                               receive_word_valid,
	output logic                               receive_fault,
	output logic                               transmit_word_accept,
	// Analog front end.
	input  hupl_pkg::hupl_ana_in_t             ana_in,
	output hupl_pkg::hupl_ana_out_t            ana_out
);
	// ****************************************************************
	// Power state and reference clock
	// ****************************************************************
	hupl_pkg::hupl_pwr_t              pwr_ff;
	hupl_pkg::hupl_pwr_t              nxt_pwr;
	logic [hupl_pkg::RESUME_W-1:0]    res_cnt_ff;
	logic [hupl_pkg::RESUME_W-1:0]    nxt_res_cnt;
	logic                             refclk_ff;
	wire                              run_w;
	wire                              susp_entry;
	wire                              ref_rise;
	wire  [1:0]                       line_now;

	assign run_w      = pwr_ff == hupl_pkg::PW_RUN;
	assign susp_entry = run_w & ~low_power_request_n;
	// Link side state moves on a reference clock rise, or clears on entry to suspend.
	assign ref_rise   = run_w & low_power_request_n & ~refclk_ff; // [RULE2]
	assign line_now   = {ana_in.dm, ana_in.dp}; // [RULE3] [RULE5]
	assign nxt_res_cnt = (pwr_ff == hupl_pkg::PW_RESUME) ?
		res_cnt_ff + hupl_pkg::RESUME_STEP : '0;

	always_comb begin
		nxt_pwr = pwr_ff;
		unique case (pwr_ff)
			hupl_pkg::PW_RUN: begin
				if (!low_power_request_n) nxt_pwr = hupl_pkg::PW_SUSP; // [RULE17]
			end
			hupl_pkg::PW_SUSP: begin
				if (low_power_request_n) nxt_pwr = hupl_pkg::PW_RESUME;
			end
			hupl_pkg::PW_RESUME: begin
				if (!low_power_request_n) nxt_pwr = hupl_pkg::PW_SUSP;
				else if (res_cnt_ff == hupl_pkg::RESUME_LAST) nxt_pwr = hupl_pkg::PW_RUN;
			end
			default: nxt_pwr = hupl_pkg::PW_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_ff     <= hupl_pkg::PW_RUN;
			res_cnt_ff <= '0;
			refclk_ff  <= 1'b0;
		end else if (ce) begin
			pwr_ff     <= nxt_pwr;
			res_cnt_ff <= nxt_res_cnt;
			refclk_ff  <= ref_rise; // [RULE2] [RULE17]
		end
	end

	// ****************************************************************
	// Link datapath
	// ****************************************************************
	logic [1:0]                       line_sync_ff;
	logic [1:0]                       opm_ff;
	logic                             txv_ff;
	logic                             acc_ff;
	logic                             full_ff;
	logic [hupl_pkg::DATA_W-1:0]      hold_ff;
	logic                             fpend_ff;
	logic                             rxv_ff;
	logic [hupl_pkg::DATA_W-1:0]      dout_ff;
	logic                             fault_ff;
	logic                             det_ff;
	logic                             ctrl_host_ff;
	hupl_pkg::hupl_ana_out_t          ana_ff;
	hupl_pkg::hupl_ana_out_t          nxt_ana;
	wire                              tx_take;
	wire                              sync_w;
	wire                              eop_w;
	wire                              rx_show;
	wire                              nxt_rxv;
	wire                              nxt_fault;
	wire                              nxt_det;

	assign tx_take = ref_rise & transmit_word_valid; // [RULE14]
	assign sync_w  = tx_take & ~txv_ff; // [RULE15]
	assign eop_w   = ref_rise & ~transmit_word_valid & txv_ff; // [RULE15]
	// A byte waits while the link transmits, so the bus never has two drivers.
	assign rx_show = ref_rise & ~transmit_word_valid; // [RULE18]
	assign nxt_rxv = susp_entry ? 1'b0 : rx_show ? full_ff :
		ref_rise ? 1'b0 : rxv_ff; // [RULE9] [RULE18]
	// The fault flag moves on every reference rise, so it lines up with its byte only while transmit valid is low.
	assign nxt_fault = susp_entry ? 1'b0 : ref_rise ? fpend_ff : fault_ff; // [RULE12] [RULE13]
	assign nxt_det = susp_entry ? 1'b0 : ref_rise ?
		(ana_in.detach_detect & ctrl_host_ff) : det_ff; // [RULE6] [RULE7]
	assign nxt_ana = '{
		pulldown_en:    host_pulldown_select, // [RULE11]
		term_off:       opm_ff == hupl_pkg::OPM_NONDRV, // [RULE1]
		stuff_bypass:   opm_ff == hupl_pkg::OPM_RAW, // [RULE1]
		clocks_stopped: nxt_pwr == hupl_pkg::PW_SUSP, // [RULE17]
		sync_start:     sync_w,
		eop_start:      eop_w,
		tx_stb:         tx_take,
		tx_byte:        tx_take ? data_in : ana_ff.tx_byte // [RULE8]
	};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_sync_ff <= hupl_pkg::LC_SE0;
			opm_ff       <= hupl_pkg::OPM_NORMAL;
			txv_ff       <= 1'b0;
			acc_ff       <= 1'b0;
			ana_ff       <= '0;
		end else if (ce) begin
			line_sync_ff <= ref_rise ? line_now : line_sync_ff; // [RULE4]
			opm_ff       <= ref_rise ? operating_mode_select : opm_ff; // [RULE1]
			txv_ff       <= ref_rise ? transmit_word_valid : txv_ff;
			acc_ff       <= susp_entry ? 1'b0 : ref_rise ? transmit_word_valid : acc_ff; // [RULE14]
			ana_ff       <= nxt_ana;
		end
	end

	// Two bytes inside one reference period overwrite each other here.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			full_ff  <= 1'b0;
			hold_ff  <= '0;
			fpend_ff <= 1'b0;
			rxv_ff   <= 1'b0;
			dout_ff  <= '0;
			fault_ff <= 1'b0;
			det_ff   <= 1'b0;
		end else if (ce) begin
			full_ff  <= ana_in.rx_stb | (full_ff & ~rx_show); // [RULE9]
			hold_ff  <= ana_in.rx_stb ? ana_in.rx_byte : hold_ff;
			fpend_ff <= ana_in.rx_err_stb | (fpend_ff & ~ref_rise); // [RULE13]
			rxv_ff   <= nxt_rxv;
			dout_ff  <= rx_show ? hold_ff : dout_ff; // [RULE8] [RULE10]
			fault_ff <= nxt_fault;
			det_ff   <= nxt_det;
		end
	end

	// ****************************************************************
	// Registers and interrupt
	// ****************************************************************
	logic [hupl_pkg::STAT_W-1:0]      status_ff;
	logic [hupl_pkg::STAT_W-1:0]      mask_ff;
	logic                             aw_hold_ff;
	logic                             w_hold_ff;
	logic [hupl_pkg::ADDR_W-1:0]      awaddr_ff;
	logic [hupl_pkg::REG_W-1:0]       wdata_ff;
	logic                             wstrb0_ff;
	logic                             awready_ff;
	logic                             wready_ff;
	logic                             bvalid_ff;
	logic [1:0]                       bresp_ff;
	logic                             arready_ff;
	logic                             rvalid_ff;
	logic [1:0]                       rresp_ff;
	logic [hupl_pkg::REG_W-1:0]       rdata_ff;
	logic                             irq_ff;
	wire                              aw_take;
	wire                              w_take;
	wire                              ar_take;
	wire                              wr_fire;
	wire                              wr_map;
	wire                              rd_map;
	wire                              nxt_aw_hold;
	wire                              nxt_w_hold;
	wire                              nxt_bvalid;
	wire                              nxt_rvalid;
	wire  [hupl_pkg::STAT_W-1:0]      ev;
	wire  [hupl_pkg::STAT_W-1:0]      w1c;
	wire  [hupl_pkg::STAT_W-1:0]      nxt_status;
	wire  [hupl_pkg::STAT_W-1:0]      nxt_mask;
	wire  [7:0]                       state_vec;
	wire  [hupl_pkg::REG_W-1:0]       rd_word;

	assign aw_take     = awvalid & awready_ff;
	assign w_take      = wvalid & wready_ff;
	assign ar_take     = arvalid & arready_ff;
	assign wr_fire     = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	assign nxt_aw_hold = aw_take | (aw_hold_ff & ~wr_fire);
	assign nxt_w_hold  = w_take | (w_hold_ff & ~wr_fire);
	assign nxt_bvalid  = wr_fire | (bvalid_ff & ~bready);
	assign nxt_rvalid  = ar_take | (rvalid_ff & ~rready);
	assign wr_map = awaddr_ff == hupl_pkg::REG_STATUS || awaddr_ff == hupl_pkg::REG_MASK ||
		awaddr_ff == hupl_pkg::REG_CTRL || awaddr_ff == hupl_pkg::REG_STATE;
	assign rd_map = araddr == hupl_pkg::REG_STATUS || araddr == hupl_pkg::REG_MASK ||
		araddr == hupl_pkg::REG_CTRL || araddr == hupl_pkg::REG_STATE;
	// Event bits from top: EOP, SYNC, byte taken, detach, fault, byte shown.
	assign ev  = {eop_w, sync_w, tx_take, nxt_det & ~det_ff, ref_rise & fpend_ff,
		rx_show & full_ff};
	assign w1c = (wr_fire && wstrb0_ff && awaddr_ff == hupl_pkg::REG_STATUS) ?
		wdata_ff[hupl_pkg::STAT_W-1:0] : '0;
	// A new event beats a write-one clear in the same cycle.
	assign nxt_status = (status_ff & ~w1c) | ev;
	assign nxt_mask = (wr_fire && wstrb0_ff && awaddr_ff == hupl_pkg::REG_MASK) ?
		wdata_ff[hupl_pkg::STAT_W-1:0] : mask_ff;
	assign state_vec = {full_ff, det_ff, ~run_w, ana_ff.pulldown_en, opm_ff, line_condition};
	assign rd_word =
		(araddr == hupl_pkg::REG_STATUS) ? hupl_pkg::REG_W'(status_ff) :
		(araddr == hupl_pkg::REG_MASK)   ? hupl_pkg::REG_W'(mask_ff) :
		(araddr == hupl_pkg::REG_CTRL)   ? hupl_pkg::REG_W'(ctrl_host_ff) :
		(araddr == hupl_pkg::REG_STATE)  ? hupl_pkg::REG_W'(state_vec) : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_ff    <= '0;
			mask_ff      <= '0;
			ctrl_host_ff <= 1'b0;
			irq_ff       <= 1'b0;
		end else if (ce) begin
			status_ff    <= nxt_status;
			mask_ff      <= nxt_mask;
			if (wr_fire && wstrb0_ff && awaddr_ff == hupl_pkg::REG_CTRL) begin
				ctrl_host_ff <= wdata_ff[hupl_pkg::CTRL_HOST];
			end
			irq_ff       <= |(nxt_status & nxt_mask);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff} <= 4'h0;
			{awready_ff, wready_ff, arready_ff} <= 3'h0;
			{awaddr_ff, wdata_ff, wstrb0_ff, rdata_ff} <= '0;
			{bresp_ff, rresp_ff} <= {hupl_pkg::RESP_OKAY, hupl_pkg::RESP_OKAY};
		end else if (ce) begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff  <= nxt_w_hold;
			bvalid_ff  <= nxt_bvalid;
			rvalid_ff  <= nxt_rvalid;
			awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_hold & ~nxt_bvalid;
			arready_ff <= ~nxt_rvalid;
			awaddr_ff  <= aw_take ? awaddr : awaddr_ff;
			wdata_ff   <= w_take ? wdata : wdata_ff;
			wstrb0_ff  <= w_take ? wstrb[0] : wstrb0_ff;
			bresp_ff   <= wr_fire ? (wr_map ? hupl_pkg::RESP_OKAY : hupl_pkg::RESP_SLVERR) : bresp_ff;
			rdata_ff   <= ar_take ? rd_word : rdata_ff;
			rresp_ff   <= ar_take ? (rd_map ? hupl_pkg::RESP_OKAY : hupl_pkg::RESP_SLVERR) : rresp_ff;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign {awready, wready, bvalid, bresp} = {awready_ff, wready_ff, bvalid_ff, bresp_ff};
	assign {arready, rvalid, rresp, rdata}  = {arready_ff, rvalid_ff, rresp_ff, rdata_ff};
	assign irq                     = irq_ff;
	assign phy_reference_clock_out = refclk_ff;
	// Suspended or resuming: the line bypasses the sampling stage.
	assign line_condition          = run_w ? line_sync_ff : line_now; // [RULE4]
	assign downstream_detach_flag  = det_ff;
	assign receive_word_valid      = rxv_ff;
	assign data_oe                 = rxv_ff; // [RULE18]
	assign data_out                = dout_ff;
	assign receive_fault           = fault_ff;
	assign transmit_word_accept    = acc_ff;
	assign ana_out                 = ana_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	wire quiet = run_w & low_power_request_n & ~transmit_word_valid;
	default clocking hupl_cb @(posedge aclk iff ce); endclocking
	default disable iff (!aresetn);
	sequence s_byte_in;
		ana_in.rx_stb && quiet;
	endsequence
	sequence s_tx_start;
		ref_rise && transmit_word_valid && !txv_ff;
	endsequence

	mode_nondrv_a: assert property (ref_rise && operating_mode_select == hupl_pkg::OPM_NONDRV // [RULE1]
		|=> ##1 ana_out.term_off && !ana_out.stuff_bypass) else $error("non-driving mode not set");
	mode_raw_a: assert property (ref_rise && operating_mode_select == hupl_pkg::OPM_RAW // [RULE1]
		|=> ##1 ana_out.stuff_bypass && !ana_out.term_off) else $error("raw mode not set");
	ref_toggle_a: assert property ((aresetn && run_w && low_power_request_n)[*2] // [RULE2]
		|-> phy_reference_clock_out != $past(phy_reference_clock_out)) else $error("clock stuck");
	line_sample_a: assert property (ref_rise |=> line_condition == $past(line_now)) // [RULE3]
		else $error("line not sampled");
	line_bypass_a: assert property (!run_w && ana_in.dp && !ana_in.dm // [RULE4]
		|-> line_condition == hupl_pkg::LC_J) else $error("suspend line not passed");
	line_se0_a: assert property (!ana_in.dp && !ana_in.dm ##1 !run_w // [RULE5]
		|-> line_condition == hupl_pkg::LC_SE0 || ana_in.dp || ana_in.dm) else $error("bad SE0");
	detach_set_a: assert property (ref_rise && ana_in.detach_detect && ctrl_host_ff // [RULE6]
		|=> downstream_detach_flag) else $error("detach not raised");
	detach_clr_a: assert property (susp_entry |=> !downstream_detach_flag) // [RULE7]
		else $error("detach not cleared");
	rx_show_a: assert property (s_byte_in |-> ##[1:4] (receive_word_valid || !quiet)) // [RULE9]
		else $error("byte not shown");
	fault_show_a: assert property (ana_in.rx_err_stb && quiet // [RULE13]
		|-> ##[1:4] (receive_fault || !quiet)) else $error("fault not shown");
	fault_align_a: assert property ($changed(receive_fault) // [RULE12]
		|-> $past(ref_rise || susp_entry)) else $error("fault off data timing");
	pulldown_a: assert property (host_pulldown_select != ana_out.pulldown_en // [RULE11]
		|=> ana_out.pulldown_en == $past(host_pulldown_select)) else $error("pull-down wrong");
	tx_take_a: assert property (tx_take |=> transmit_word_accept && ana_out.tx_stb // [RULE14]
		&& ana_out.tx_byte == $past(data_in)) else $error("byte not taken");
	sync_start_a: assert property (s_tx_start |=> ana_out.sync_start ##1 !ana_out.sync_start) // [RULE15]
		else $error("sync not started");
	bus_one_a: assert property (data_oe |-> receive_word_valid && $past(!transmit_word_valid || !ref_rise)) // [RULE18]
		else $error("bus contention");
	suspend_a: assert property ((!low_power_request_n)[*2] // [RULE17]
		|-> ana_out.clocks_stopped && !phy_reference_clock_out) else $error("clock not stopped");
endmodule

// file: sim/hupl_link_model.sv
// Behavioural link controller on the far side of the transceiver link interface.
`timescale 1ns/1ps
module hupl_link_model (
	// Clock and reset.
	input  logic       aclk,
	input  logic       aresetn,
	// Device side.
	input  logic       ref_clk,
	input  logic       rx_valid,
	input  logic [7:0] rx_data,
	input  logic       rx_fault,
	output logic       transmit_word_valid,
	output logic [7:0] data_in,
	// Bench side.
	input  logic       tx_go,
	input  logic [7:0] tx_byte,
	output logic [7:0] got_byte,
	output logic       got_fault,
	output logic [7:0] got_cnt
);
	logic [2:0] rises_ff;
	wire        send = tx_go && rises_ff == 3'h5;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rises_ff            <= 3'h0;
			transmit_word_valid <= 1'b0;
			data_in             <= 8'h00;
			got_cnt             <= 8'h00;
		end else if (!ref_clk) begin
			if (rises_ff != 3'h5)
				rises_ff <= rises_ff + 3'h1;
			if (rx_valid) begin
				got_byte  <= rx_data;
				got_fault <= rx_fault;
				got_cnt   <= got_cnt + 8'h01;
			end
		end else begin
			// Drive only mid-period, so the device never samples a moving line.
			transmit_word_valid <= send;
			data_in             <= send ? tx_byte : 8'h00;
		end
	end
endmodule

// file: sim/hupl_top_tb.sv
// Self-checking bench of the link-side logic and its register bus.
`timescale 1ns/1ps
module hupl_top_tb;
	localparam logic [1:0] OK = hupl_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = hupl_pkg::RESP_SLVERR;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, tx_go = 1'b0, host_pulldown_select = 1'b0, ce = 1'b1;
	logic low_power_request_n = 1'b1, awready, wready, bvalid, arready, rvalid, irq, data_oe;
	logic phy_reference_clock_out, downstream_detach_flag, receive_word_valid, receive_fault;
	logic transmit_word_accept, transmit_word_valid, got_fault;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, tx_byte = 8'h00, data_in, data_out, got_byte, got_cnt;
	logic [31:0] wdata = 32'h0, rnd = 32'hD81B6C2E, rd, rdata;
	logic [1:0] operating_mode_select = 2'h0, bresp, rresp, line_condition;
	hupl_pkg::hupl_ana_in_t  ana_in = '0;
	hupl_pkg::hupl_ana_out_t ana_out;
	int n_mismatch = 0, checks = 0, i, k, n;
	always #10 aclk = ~aclk;
	hupl_top dut (.aclk, .aresetn, .ce, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
		.wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .irq, .operating_mode_select,
		.host_pulldown_select, .low_power_request_n, .transmit_word_valid, .data_in, .data_out,
		.data_oe, .phy_reference_clock_out, .line_condition, .downstream_detach_flag,
		.receive_word_valid, .receive_fault, .transmit_word_accept, .ana_in, .ana_out);
	hupl_link_model link (.aclk, .aresetn, .ref_clk(phy_reference_clock_out),
		.rx_valid(receive_word_valid), .rx_data(data_out), .rx_fault(receive_fault),
		.transmit_word_valid, .data_in, .tx_go, .tx_byte, .got_byte, .got_fault, .got_cnt);
	// ****************************************************************
	// Bench tasks
	// ****************************************************************
	task automatic conclude();
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// A wait that used up its bound ends the run at once.
	task automatic bound(input int cnt, input int lim);
		if (cnt >= lim) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, cnt, lim);
			conclude();
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge aclk);
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int m;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		for (m = 0; m < 50; m++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bound(m, 50);
		bready <= 1'b0;
		cmp(32'(bresp), 32'(er));
	endtask
	task automatic axr(input logic [7:0] a, input logic [1:0] er);
		int m;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (m = 0; m < 50; m++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		bound(m, 50);
		rready <= 1'b0;
		rd = rdata;
		cmp(32'(rresp), 32'(er));
	endtask
	function automatic logic [1:0] lc_exp(input logic dp, input logic dm);
		case ({dm, dp})
			2'h0: return hupl_pkg::LC_SE0;
			2'h1: return hupl_pkg::LC_J;
			2'h2: return hupl_pkg::LC_K;
			default: return hupl_pkg::LC_SE1;
		endcase
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	initial begin
		cyc(4);
		aresetn <= 1'b1;
		// Reset values, the unmapped address last.
		for (k = 0; k < 5; k++) begin
			axr(8'(k * 4), (k == 4) ? ERR : OK);
			cmp(rd, 32'h0);
		end
		axw(8'h10, 32'hFF, ERR);
		for (k = 0; k < 16; k++) begin
			rnd = lfsr(rnd);
			ana_in.dp <= rnd[0];
			ana_in.dm <= rnd[1];
			host_pulldown_select <= rnd[2];
			operating_mode_select <= 2'(k);
			cyc(8);
			cmp(32'(line_condition), 32'(lc_exp(rnd[0], rnd[1])));
			cmp(32'(ana_out.pulldown_en), 32'(rnd[2]));
			cmp(32'({ana_out.term_off, ana_out.stuff_bypass}), 32'({k % 4 == 1, k % 4 == 2}));
		end
		operating_mode_select <= 2'h0;
		for (k = 0; k < 8; k++) begin
			rnd = lfsr(rnd);
			i = got_cnt;
			ana_in.rx_byte <= rnd[7:0];
			{ana_in.rx_stb, ana_in.rx_err_stb} <= {1'b1, rnd[8]};
			@(posedge aclk);
			{ana_in.rx_stb, ana_in.rx_err_stb} <= 2'h0;
			for (n = 0; n < 20 && got_cnt == 8'(i); n++) @(posedge aclk);
			bound(n, 20);
			cmp(32'(got_byte), 32'(rnd[7:0]));
			cmp(32'(got_fault), 32'(rnd[8]));
		end
		axw(hupl_pkg::REG_MASK, 32'h01, OK);
		cyc(2);
		cmp(32'(irq), 32'h1);
		axw(hupl_pkg::REG_STATUS, 32'h3F, OK);
		cyc(2);
		cmp(32'(irq), 32'h0);
		tx_byte <= rnd[15:8];
		tx_go <= 1'b1;
		for (k = 0; k < 4; k++) begin
			for (n = 0; n < 40 && ana_out.tx_stb !== 1'b1; n++) @(posedge aclk);
			bound(n, 40);
			cmp(32'(ana_out.tx_byte), 32'(data_in));
			cmp(32'(transmit_word_accept), 32'h1);
			cmp(32'(data_oe), 32'h0);
			rnd = lfsr(rnd);
			tx_byte <= rnd[7:0];
			@(posedge aclk);
		end
		tx_go <= 1'b0;
		for (n = 0; n < 40 && ana_out.eop_start !== 1'b1; n++) @(posedge aclk);
		bound(n, 40);
		axr(hupl_pkg::REG_STATUS, OK);
		cmp(32'(rd[5:3]), 32'h7);
		cmp(32'(irq), 32'h0);
		axw(hupl_pkg::REG_CTRL, 32'h1, OK);
		ana_in.detach_detect <= 1'b1;
		for (n = 0; n < 20 && downstream_detach_flag !== 1'b1; n++) @(posedge aclk);
		bound(n, 20);
		low_power_request_n <= 1'b0;
		cyc(3);
		cmp(32'({downstream_detach_flag, ana_out.clocks_stopped, phy_reference_clock_out}), 32'h2);
		ana_in.dp <= ~ana_in.dp;
		@(negedge aclk);
		cmp(32'(line_condition), 32'(lc_exp(ana_in.dp, ana_in.dm)));
		@(posedge aclk);
		low_power_request_n <= 1'b1;
		for (n = 0; n < 60 && phy_reference_clock_out !== 1'b1; n++) @(posedge aclk);
		bound(n, 60);
		ana_in.dp <= ~ana_in.dp;
		@(negedge aclk);
		cmp(32'(line_condition), 32'(lc_exp(~ana_in.dp, ana_in.dm)));
		cyc(6);
		cmp(32'(line_condition), 32'(lc_exp(ana_in.dp, ana_in.dm)));
		// A low enable must freeze the reference clock where it stands.
		ce <= 1'b0;
		@(posedge aclk);
		k = phy_reference_clock_out;
		cyc(4);
		cmp(32'(phy_reference_clock_out), 32'(k));
		ce <= 1'b1;
		conclude();
	end
endmodule
